// file: core/tdc_delay_counter.sv
// Delay-counter timer channel with its AHB-Lite register slave
//
// Operation
// R1: Software selects master output mode for delays
// R2: Output level ignored in master mode
// R3: Disabled unit: no clock, registers inaccessible
// R4: Enabling unit starts clock, channel stopped
// R5: Two prescaled clocks from prescale select
// R6: Software configures channel before starting it
// R7: Start bit triggers and reads zero
// R8: Start write sets enable status, awaits trigger
// R9: Trigger loads data into counter, counts down
// R10: Counter reaching zero raises channel interrupt
// R11: After terminal count, halt holding all ones
// R12: Sequence repeats on every later trigger
// R13: Data register writable while running
// R14: Counter readable at any time
// R15: Software leaves mode and output bits alone
// R16: Stop bit stops channel and reads zero
// R17: Stop clears enable status, counting ceases
// R18: Counter keeps its value after stop
// R19: Disabling unit returns registers to initial
// R20: Interval is count period times data plus one
// R21: Trigger pin sampled on operating clock
// R22: New data value used at next load
// R23: Split channel counts only lower half
// R24: Count on strobes from selected prescaled clock
module tdc_delay_counter (
   input  wire logic         mclk,
   input  wire logic         rstn,
   input  wire logic         hsel,
   input  wire logic [31:0]  haddr,
   input  wire logic [1:0]   htrans,
   input  wire logic         hwrite,
   input  wire logic [2:0]   hsize,
   input  wire logic         hready,
   input  wire logic [31:0]  hwdata,
   output logic [31:0]       hrdata,
   output logic              hreadyout,
   output logic              hresp,
   input  wire logic         trigInPin,
   output logic              channelInterrupt,
   output logic              timerOut,
   output logic              timerOutEn,
   output logic              unitClockOn
);
   import tdc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic        unitEn_r;       // Unit enable bit
   logic [7:0]  prescale_r;     // Two divider selects
   logic [3:0]  mode_r;         // Clock select, edge select, split
   logic        nfilt_r;        // Noise filter enable
   logic [15:0] data_r;         // Channel data value
   logic [15:0] cnt_r;          // Channel counter
   logic        enStat_r;       // Channel enable status
   logic [3:0]  outCtl_r;       // Output value, enable, mode, level
   tdc_state_t  state_r;        // Channel sequencer
   logic        wrPend_r;       // Write data phase pending
   logic [7:0]  wrAddr_r;       // Address of pending write
   logic        wrWord_r;       // Pending write is a whole word
   logic        accept;         // Address phase taken this cycle
   logic        wrOk;           // Write lands in this cycle
   logic        wrUnit;         // Write to the unit enable word
   logic        startWr;        // Start trigger written
   logic        stopWr;         // Stop trigger written
   logic        trig;           // Start trigger detected
   logic        tickA;          // Prescaled strobe A
   logic        tickB;          // Prescaled strobe B
   logic        countTick;      // Selected operating clock strobe
   logic        pinEdge;        // Valid edge on trigger pin
   logic        split;          // Lower 8-bit half only

   ////////////////////////////////////////////////////////////////////////////
   // Bus handshake: zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign accept    = hsel && htrans[1] && hready;
   assign wrOk      = wrPend_r && wrWord_r && unitEn_r;  // R3
   assign wrUnit    = wrPend_r && wrWord_r && (wrAddr_r == OFF_UNIT_EN);
   assign startWr   = wrOk && (wrAddr_r == OFF_START) && hwdata[0];
   assign stopWr    = wrOk && (wrAddr_r == OFF_STOP) && hwdata[0];
   assign split     = mode_r[MODE_SPLIT];
   assign countTick = mode_r[MODE_CLKSEL] ? tickB : tickA;  // R24
   assign unitClockOn = unitEn_r;

   // Start while enabled acts as a trigger; otherwise only the pin edge
   assign trig = pinEdge || (startWr && enStat_r);  // R8

   // Read value of one register word; trigger words always read zero
   function automatic logic [31:0] readWord(input logic [7:0] a);
      logic [31:0] v;
      v = REG_RST;
      if (a == OFF_UNIT_EN) begin
         v[0] = unitEn_r;
      end else if (!unitEn_r) begin
         v = REG_RST;  // R3
      end else if (a == OFF_PRESCALE) begin
         v[7:0] = prescale_r;
      end else if (a == OFF_MODE) begin
         v[3:0] = mode_r;
      end else if (a == OFF_NFILT) begin
         v[0] = nfilt_r;
      end else if (a == OFF_DATA) begin
         v[15:0] = data_r;
      end else if (a == OFF_COUNT) begin
         v[15:0] = cnt_r;  // R14
      end else if (a == OFF_ENSTAT) begin
         v[0] = enStat_r;
      end else if (a == OFF_OUTCTL) begin
         v[3:0] = outCtl_r;
      end else begin
         v = REG_RST;  // R7 R16
      end
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Address phase capture for writes
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wrPend_r <= 1'b0;
         wrAddr_r <= 8'h00;
         wrWord_r <= 1'b0;
      end else begin
         wrPend_r <= accept && hwrite;
         wrAddr_r <= haddr[7:0];
         wrWord_r <= hsize == HSIZE_WORD;
      end
   end

   // Read data prepared at the address phase, stands in the data phase
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         hrdata <= REG_RST;
      end else if (accept && !hwrite) begin
         hrdata <= readWord(haddr[7:0]);
      end else begin
         hrdata <= REG_RST;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Unit enable: the only word reachable while the unit is off
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         unitEn_r <= 1'b0;
      end else if (wrUnit) begin
         unitEn_r <= hwdata[0];  // R4
      end
   end

   // Configuration words; cleared whenever the unit is off
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prescale_r <= 8'h00;
         mode_r     <= 4'h0;
         nfilt_r    <= 1'b0;
         outCtl_r   <= 4'h0;
      end else if (!unitEn_r) begin
         prescale_r <= 8'h00;  // R19
         mode_r     <= 4'h0;
         nfilt_r    <= 1'b0;
         outCtl_r   <= 4'h0;
      end else if (wrOk) begin
         if (wrAddr_r == OFF_PRESCALE) begin
            prescale_r <= hwdata[7:0];
         end else if (wrAddr_r == OFF_MODE) begin
            mode_r <= hwdata[3:0];
         end else if (wrAddr_r == OFF_NFILT) begin
            nfilt_r <= hwdata[0];
         end else if (wrAddr_r == OFF_OUTCTL) begin
            outCtl_r <= hwdata[3:0];
         end
      end
   end

   // Data word is writable at any time the unit is on; counter only sees it at a load
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         data_r <= DATA_RST;
      end else if (!unitEn_r) begin
         data_r <= DATA_RST;  // R19
      end else if (wrOk && (wrAddr_r == OFF_DATA)) begin
         data_r <= hwdata[15:0];  // R13 R22
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Count-clock strobes from the prescale select word
   tdc_prescaler #(
      .DIV_W (16)
   ) u_prescaler (
      .mclk   (mclk),
      .rstn   (rstn),
      .enable (unitEn_r),
      .selA   (prescale_r[PRESC_A_LSB +: PRESC_SEL_W]),
      .selB   (prescale_r[PRESC_B_LSB +: PRESC_SEL_W]),
      .tickA  (tickA),
      .tickB  (tickB)
   );

   // Pin edge detection, sampled on the channel operating clock
   tdc_trigger_sync u_trigger (
      .mclk       (mclk),
      .rstn       (rstn),
      .enable     (unitEn_r),
      .sampleTick (countTick),
      .filterEn   (nfilt_r),
      .edgeSel    (mode_r[MODE_EDGE_LSB +: 2]),
      .pinIn      (trigInPin),
      .edgeSeen   (pinEdge)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Channel sequencer: stop wins over start in the same cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_r  <= ST_STOPPED;
         enStat_r <= 1'b0;
      end else if (!unitEn_r) begin
         state_r  <= ST_STOPPED;  // R4 R19
         enStat_r <= 1'b0;
      end else if (stopWr) begin
         state_r  <= ST_STOPPED;  // R17
         enStat_r <= 1'b0;
      end else begin
         case (state_r)
            ST_STOPPED: begin
               if (startWr) begin
                  state_r  <= ST_WAIT;  // R8
                  enStat_r <= 1'b1;
               end
            end
            ST_WAIT: begin
               if (trig) begin
                  state_r <= ST_COUNT;  // R9
               end
            end
            ST_COUNT: begin
               if (trig) begin
                  state_r <= ST_COUNT;  // R12
               end else if (countTick && (split ? cnt_r[7:0] == LOW_ZERO
                                               : cnt_r == CNT_ZERO)) begin
                  state_r <= ST_WAIT;  // R11
               end
            end
            default: state_r <= ST_STOPPED;
         endcase
      end
   end

   // Counter: load on trigger, step on strobe, halt at all ones
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= CNT_RST;
      end else if (!unitEn_r) begin
         cnt_r <= CNT_RST;  // R19
      end else if (stopWr || (state_r == ST_STOPPED)) begin
         cnt_r <= cnt_r;  // R18
      end else if (trig) begin
         if (split) begin
            cnt_r <= {cnt_r[15:8], data_r[7:0]};  // R9 R23
         end else begin
            cnt_r <= data_r;  // R9 R22
         end
      end else if ((state_r == ST_COUNT) && countTick) begin
         if (split) begin
            if (cnt_r[7:0] == LOW_ZERO) begin
               cnt_r <= {cnt_r[15:8], LOW_HALT};  // R11 R23
            end else begin
               cnt_r <= {cnt_r[15:8], cnt_r[7:0] - 8'h01};  // R24
            end
         end else if (cnt_r == CNT_ZERO) begin
            cnt_r <= CNT_HALT;  // R11
         end else begin
            cnt_r <= cnt_r - 16'h0001;  // R20 R24
         end
      end
   end

   // Interrupt request: one-cycle pulse on the terminal strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         channelInterrupt <= 1'b0;
      end else begin
         channelInterrupt <= unitEn_r && !stopWr && !trig && (state_r == ST_COUNT)
                             && countTick && (split ? cnt_r[7:0] == LOW_ZERO
                                                    : cnt_r == CNT_ZERO);  // R10 R20
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output pin: the level bit only counts in slave mode
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         timerOut   <= 1'b0;
         timerOutEn <= 1'b0;
      end else begin
         timerOutEn <= outCtl_r[OUT_ENABLE];
         if (!outCtl_r[OUT_MODE]) begin
            timerOut <= outCtl_r[OUT_ENABLE] && outCtl_r[OUT_VALUE];  // R2
         end else begin
            timerOut <= outCtl_r[OUT_ENABLE] &&
                        (outCtl_r[OUT_VALUE] ^ outCtl_r[OUT_LEVEL]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);

   a_irq_halts: assert property (channelInterrupt |-> cnt_r[7:0] == LOW_HALT &&
      state_r == ST_WAIT) else $error("interrupt without halt");  // R10 R11
   a_load_data: assert property ((state_r == ST_WAIT) && trig && !stopWr && !split && unitEn_r
      |=> cnt_r == $past(data_r)) else $error("trigger did not load data");  // R9
   a_stop_holds: assert property ((state_r == ST_STOPPED) && unitEn_r && $past(unitEn_r)
      |-> $stable(cnt_r)) else $error("counter moved while stopped");  // R18
   a_stop_clears: assert property (stopWr |=> !enStat_r && state_r == ST_STOPPED)
      else $error("stop did not clear status");  // R17 R16
   a_start_sets: assert property ((state_r == ST_STOPPED) && startWr && !stopWr
      |=> enStat_r ##0 state_r == ST_WAIT) else $error("start did not arm");  // R8 R7
   a_off_reads_zero: assert property (accept && !hwrite && !unitEn_r &&
      haddr[7:0] != OFF_UNIT_EN |=> hrdata == REG_RST)
      else $error("read while disabled");  // R3
   a_off_init: assert property (!unitEn_r |=> state_r == ST_STOPPED && data_r == DATA_RST
      && cnt_r == CNT_RST) else $error("disable did not initialise");  // R19
   a_count_step: assert property ((state_r == ST_COUNT) && countTick && !trig && !stopWr
      && !split && cnt_r != CNT_ZERO && unitEn_r |=> cnt_r == $past(cnt_r) - 16'h0001)
      else $error("count step wrong");  // R24 R20
   a_count_waits: assert property ((state_r == ST_COUNT) && !countTick && !trig &&
      !stopWr && unitEn_r |=> $stable(cnt_r)) else $error("count without strobe");  // R24
   a_split_upper: assert property ((state_r != ST_STOPPED) && split && unitEn_r &&
      $past(split) |-> $stable(cnt_r[15:8])) else $error("upper half moved");  // R23
   a_level_ignored: assert property (!$past(outCtl_r[OUT_MODE]) |-> timerOut ==
      ($past(outCtl_r[OUT_ENABLE]) && $past(outCtl_r[OUT_VALUE])))
      else $error("level bit used in master mode");  // R2

   c_irq: cover property (channelInterrupt);
   c_retrigger: cover property ((state_r == ST_COUNT) && trig);
   c_stop_counting: cover property ((state_r == ST_COUNT) && stopWr);
   c_second_irq: cover property (channelInterrupt ##[1:200] channelInterrupt);

endmodule

// file: core/tdc_pkg.sv
// Shared constants and types of the delay-counter timer channel
package tdc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFF_UNIT_EN  = 8'h00;  // Unit enable
   localparam logic [7:0] OFF_PRESCALE = 8'h04;  // Clock prescale select
   localparam logic [7:0] OFF_MODE     = 8'h08;  // Channel mode
   localparam logic [7:0] OFF_NFILT    = 8'h0C;  // Noise filter enable
   localparam logic [7:0] OFF_DATA     = 8'h10;  // Channel data
   localparam logic [7:0] OFF_COUNT    = 8'h14;  // Channel count, read only
   localparam logic [7:0] OFF_START    = 8'h18;  // Start trigger, reads zero
   localparam logic [7:0] OFF_STOP     = 8'h1C;  // Stop trigger, reads zero
   localparam logic [7:0] OFF_ENSTAT   = 8'h20;  // Channel enable status
   localparam logic [7:0] OFF_OUTCTL   = 8'h24;  // Output control bits

   ////////////////////////////////////////////////////////////////////////////
   // Field positions
   localparam int PRESC_A_LSB    = 0;  // Divider select of clock A
   localparam int PRESC_B_LSB    = 4;  // Divider select of clock B
   localparam int PRESC_SEL_W    = 4;  // Width of one divider select
   localparam int MODE_CLKSEL    = 0;  // 0: clock A, 1: clock B
   localparam int MODE_EDGE_LSB  = 1;  // Two bits of edge select
   localparam int MODE_SPLIT     = 3;  // Split into 8-bit halves
   localparam int OUT_VALUE      = 0;  // Output value bit
   localparam int OUT_ENABLE     = 1;  // Output enable bit
   localparam int OUT_MODE       = 2;  // Output mode bit, 0 = master
   localparam int OUT_LEVEL      = 3;  // Output level bit

   ////////////////////////////////////////////////////////////////////////////
   // Reset and terminal values
   localparam logic [31:0] REG_RST   = 32'h0000_0000;
   localparam logic [15:0] DATA_RST  = 16'h0000;
   localparam logic [15:0] CNT_RST   = 16'hFFFF;
   localparam logic [15:0] CNT_HALT  = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO  = 16'h0000;
   localparam logic [7:0]  LOW_HALT  = 8'hFF;
   localparam logic [7:0]  LOW_ZERO  = 8'h00;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Enumerations
   typedef enum logic [1:0] {EDGE_FALL, EDGE_RISE, EDGE_BOTH, EDGE_NONE} tdc_edge_t;
   typedef enum logic [1:0] {ST_STOPPED, ST_WAIT, ST_COUNT} tdc_state_t;

endpackage

// file: core/tdc_prescaler.sv
// Free-running divider that makes the two prescaled count-clock strobes
module tdc_prescaler #(
   parameter int DIV_W = 16
) (
   input  wire logic                             mclk,
   input  wire logic                             rstn,
   input  wire logic                             enable,
   input  wire logic [tdc_pkg::PRESC_SEL_W-1:0]  selA,
   input  wire logic [tdc_pkg::PRESC_SEL_W-1:0]  selB,
   output logic                                  tickA,
   output logic                                  tickB
);
   import tdc_pkg::*;

   logic [DIV_W-1:0] divCnt_r;  // Shared divider chain

   // Strobe once every 2**sel cycles, when the low sel bits are all ones
   function automatic logic tickFor(input logic [DIV_W-1:0] cnt,
                                    input logic [PRESC_SEL_W-1:0] sel);
      logic [DIV_W-1:0] mask;
      mask = DIV_W'((DIV_W'(1) << sel) - DIV_W'(1));
      return (cnt & mask) == mask;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Divider is held at zero while the unit is unclocked
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         divCnt_r <= '0;
      end else if (!enable) begin
         divCnt_r <= '0;
      end else begin
         divCnt_r <= divCnt_r + DIV_W'(1);
      end
   end

   // Registered strobes; both share one chain so they stay phase related
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tickA <= 1'b0;
         tickB <= 1'b0;
      end else begin
         tickA <= enable && tickFor(divCnt_r, selA);  // R5
         tickB <= enable && tickFor(divCnt_r, selB);  // R5
      end
   end

endmodule

// file: core/tdc_trigger_sync.sv
// Trigger pin synchroniser, optional noise filter and valid-edge detector
module tdc_trigger_sync (
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        enable,
   input  wire logic        sampleTick,
   input  wire logic        filterEn,
   input  wire logic [1:0]  edgeSel,
   input  wire logic        pinIn,
   output logic             edgeSeen
);
   import tdc_pkg::*;

   logic sync1_r;    // First stage, read only by sync2_r
   logic sync2_r;    // Second stage
   logic sample_r;   // Previous operating-clock sample
   logic level_r;    // Accepted (filtered) level
   logic newLevel;   // Level after this sample
   logic edgeOk;     // Change matches the chosen edge

   ////////////////////////////////////////////////////////////////////////////
   // Two-flop synchroniser for the asynchronous pin
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
      end else begin
         sync1_r <= pinIn;
         sync2_r <= sync1_r;
      end
   end

   // Filter needs two equal samples in a row before a level is accepted
   always_comb begin
      newLevel = level_r;
      if (!filterEn || (sample_r == sync2_r)) begin
         newLevel = sync2_r;
      end
      case (tdc_edge_t'(edgeSel))
         EDGE_FALL: edgeOk = level_r && !newLevel;
         EDGE_RISE: edgeOk = !level_r && newLevel;
         EDGE_BOTH: edgeOk = level_r != newLevel;
         default:   edgeOk = 1'b0;
      endcase
   end

   // Sampling only on the operating clock: up to one period of latency
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         sample_r <= 1'b0;
         level_r  <= 1'b0;
         edgeSeen <= 1'b0;
      end else if (!enable) begin
         sample_r <= 1'b0;
         level_r  <= 1'b0;
         edgeSeen <= 1'b0;
      end else begin
         edgeSeen <= sampleTick && edgeOk;  // R21
         if (sampleTick) begin
            sample_r <= sync2_r;  // R21
            level_r  <= newLevel;
         end
      end
   end

endmodule

// file: testbench/tb_tdc_delay_counter.sv
// Self-checking testbench of the delay-counter timer channel
module tb_tdc_delay_counter;
   timeunit 1ns;
   timeprecision 1ps;
   import tdc_pkg::*;

   logic        mclk, rstn, hsel, hwrite, pin;    // Bench driven controls
   logic [31:0] haddr, hwdata, hrdata;            // Bus address and data
   logic [1:0]  htrans;                           // Transfer kind
   logic        hreadyout, hresp, irq, tOut, tEn, clkOn; // Design outputs
   int          num_errors = 0;                   // Mismatch count
   int          compares = 0;                     // Comparison count
   int          n;                                // Cycles to interrupt
   logic [31:0] q;                                // Scratch read value

   ////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   always #2.5 mclk = ~mclk;

   tdc_trig_src u_src (.mclk(mclk), .pinOut(pin));

   // Bus hready is the one slave's hreadyout
   tdc_delay_counter u_dut (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(HSIZE_WORD), .hready(hreadyout),
      .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .trigInPin(pin), .channelInterrupt(irq), .timerOut(tOut),
      .timerOutEn(tEn), .unitClockOn(clkOn));

   ////////////////////////////////////////////////////////////////////////
   // Verdict and end of run, also reached from a spent wait
   task automatic wrap_up();
      $display("compares=%0d num_errors=%0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Value compare; case inequality keeps unknowns from matching
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   // Range compare for figures known only within a strobe
   task automatic rng(input string nm, input int lo, input int hi, input int g);
      compares++;
      if (g < lo || g > hi) begin
         num_errors++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
      end
   endtask

   // Bounded wait for hready high at a rising edge
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (k >= 50) begin
         num_errors++;
         wrap_up();
      end
   endtask

   // One single word transfer: address phase, then data phase
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge mclk);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr  <= {24'h000000, a};
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk($sformatf("reg %h", a), e, r);
   endtask

   // Bounded wait for the interrupt pulse, counting cycles
   task automatic wait_irq(output int c);
      c = 0;
      #1;
      while (irq !== 1'b1 && c < 500) begin
         @(posedge mclk);
         #1;
         c++;
      end
      if (c >= 500) begin
         num_errors++;
         wrap_up();
      end
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_disabled();
      wr(OFF_DATA, 32'h55);
      rdc(OFF_DATA, 32'h0);
      chk("unitClockOn", 32'h0, {31'h0, clkOn});
      chk("hresp", 32'h0, {31'h0, hresp});
   endtask

   task automatic t_enable();
      wr(OFF_UNIT_EN, 32'h1);
      rdc(OFF_ENSTAT, 32'h0);
      chk("unitClockOn", 32'h1, {31'h0, clkOn});
      rdc(OFF_COUNT, 32'h0000FFFF);
      wr(OFF_PRESCALE, 32'h1);
      wr(OFF_OUTCTL, 32'h0);
      wr(OFF_NFILT, 32'h0);
      wr(OFF_MODE, 32'h2);
   endtask

   // Strobe every two cycles, so the delay is (data+1)*2 cycles
   task automatic t_soft();
      wr(OFF_DATA, 32'h5);
      wr(OFF_START, 32'h1);
      rdc(OFF_START, 32'h0);
      rdc(OFF_ENSTAT, 32'h1);
      wr(OFF_START, 32'h1);
      wait_irq(n);
      rng("delay", 12, 17, n);
      rdc(OFF_COUNT, 32'h0000FFFF);
   endtask

   // Delay counted from the pin rise: interval plus sync and sampling
   task automatic t_pin();
      fork
         u_src.pulse(6);
      join_none
      wait_irq(n);
      rng("pin delay", 14, 20, n);
      rdc(OFF_COUNT, 32'h0000FFFF);
   endtask

   // Data rewritten mid-count must not reach the running count
   task automatic t_stop();
      wr(OFF_DATA, 32'h28);
      wr(OFF_START, 32'h1);
      wr(OFF_DATA, 32'h1);
      bus(1'b0, OFF_COUNT, 32'h0, q);
      rng("count", 2, 40, int'(q));
      wr(OFF_STOP, 32'h1);
      rdc(OFF_STOP, 32'h0);
      rdc(OFF_ENSTAT, 32'h0);
      bus(1'b0, OFF_COUNT, 32'h0, q);
      repeat (10) @(posedge mclk);
      rdc(OFF_COUNT, q);
   endtask

   // Master mode: the level bit must not invert the pin
   task automatic t_out();
      wr(OFF_OUTCTL, 32'hA);
      repeat (2) @(posedge mclk);
      chk("timerOut", 32'h0, {31'h0, tOut});
      chk("timerOutEn", 32'h1, {31'h0, tEn});
      wr(OFF_OUTCTL, 32'hB);
      repeat (2) @(posedge mclk);
      chk("timerOut", 32'h1, {31'h0, tOut});
      wr(OFF_OUTCTL, 32'hF);
      repeat (2) @(posedge mclk);
      chk("timerOut slave", 32'h0, {31'h0, tOut});
   endtask

   task automatic t_reinit();
      wr(OFF_UNIT_EN, 32'h0);
      wr(OFF_UNIT_EN, 32'h1);
      rdc(OFF_DATA, 32'h0);
      rdc(OFF_MODE, 32'h0);
      rdc(OFF_COUNT, 32'h0000FFFF);
      rdc(8'h3C, 32'h0);
   endtask

   // Split: low byte 3 with a strobe every cycle gives four cycles
   task automatic t_split();
      wr(OFF_MODE, 32'h8);
      wr(OFF_DATA, 32'h0203);
      wr(OFF_START, 32'h1);
      wr(OFF_START, 32'h1);
      wait_irq(n);
      rng("split delay", 4, 4, n);
      rdc(OFF_COUNT, 32'h0000FFFF);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Reset for two cycles, then the scenarios in order
   initial begin
      mclk = 1'b0;
      rstn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      repeat (2) @(posedge mclk);
      rstn <= 1'b1;
      t_disabled();
      t_enable();
      t_soft();
      t_pin();
      t_stop();
      t_out();
      t_reinit();
      t_split();
      wrap_up();
   end
endmodule

// file: testbench/tdc_trig_src.sv
// Model of the external event source that drives the trigger pin
module tdc_trig_src (
   input  wire logic mclk,
   output logic      pinOut
);
   timeunit 1ns;
   timeprecision 1ps;

   // Pin rests low between events, so every pulse gives one rising edge
   initial pinOut = 1'b0;

   // Pulse wide enough for the synchroniser and the strobe sampling
   task automatic pulse(input int width);
      @(posedge mclk);
      pinOut <= 1'b1;
      repeat (width) @(posedge mclk);
      pinOut <= 1'b0;
   endtask
endmodule
